// [core/mst_follow.sv]
// Master-slave torque follow logic with AXI4-Lite register slave
//
// Contract
// - Master-slave use needs forced-stop deceleration off; otherwise raise parameter error.
// - Master sends its torque over the ring; slave uses received torque as command.
// - Slave servo-on while its master is servo-off produces zero torque.
// - Role set on an unsupported control mode raises parameter error.
// - Standard mode: semi-closed allows both roles, fully closed allows master only.
// - Master: master bit 1, slave bit 0; slave opposite; both reset to 0.
// - Master selectors 00000038 torque, 0000003A speed limit; both reset 00000000.
// - Slave follows master number 0 to 32; master keeps it at 0.
// - Slave scales received torque by coefficient 0 to 500, reset 0.
// - Slave speed limit scaled by coefficient 0 to 500, floored by adjust 0 to 32767.
// - Master travel direction 0 CCW, 1 CW for increasing address.
// - Slave travel direction 0 keeps master torque polarity, 1 inverts it.
// - Master-slave is refused together with continuous switching to torque control.
// - Unlinked slave reaching its speed limit raises overspeed alarm.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`default_nettype none
module mst_follow
  import mst_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]       s_awaddr_i,
  input  wire logic                    s_awvalid_i,
  output logic                         s_awready_o,
  input  wire logic [DATA_W-1:0]       s_wdata_i,
  input  wire logic [3:0]              s_wstrb_i,
  input  wire logic                    s_wvalid_i,
  output logic                         s_wready_o,
  output logic [1:0]                   s_bresp_o,
  output logic                         s_bvalid_o,
  input  wire logic                    s_bready_i,
  input  wire logic [ADDR_W-1:0]       s_araddr_i,
  input  wire logic                    s_arvalid_i,
  output logic                         s_arready_o,
  output logic [DATA_W-1:0]            s_rdata_o,
  output logic [1:0]                   s_rresp_o,
  output logic                         s_rvalid_o,
  input  wire logic                    s_rready_i,
  // Local control loop side
  input  wire logic                    servo_on_i,
  input  wire logic signed [TRQ_W-1:0] local_torque_i,
  input  wire logic [TRQ_W-1:0]        local_speed_limit_i,
  input  wire logic signed [TRQ_W-1:0] motor_speed_i,
  // Drive-to-drive ring
  input  wire mst_link_t               rx_link_i,
  output mst_link_t                    tx_link_o,
  // Results
  output logic signed [TRQ_W-1:0]      torque_cmd_o,
  output logic [TRQ_W-1:0]             speed_limit_o,
  output logic                         motor_dir_cw_o,
  output logic                         parameter_error_alarm_o,
  output logic                         overspeed_alarm_o,
  output logic                         irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [31:0]          ctrl_r;
  logic [31:0]          tx_sel1_r;
  logic [31:0]          tx_sel2_r;
  logic [5:0]           master_num_r;
  logic [8:0]           trq_coef_r;
  logic [8:0]           spd_coef_r;
  logic [14:0]          spd_adj_r;
  logic [EV_N-1:0]      irq_stat_r;
  logic [EV_N-1:0]      irq_en_r;

  wire logic            master_role_select      = ctrl_r[CTL_MASTER_BIT];
  wire logic            slave_role_select       = ctrl_r[CTL_SLAVE_BIT];
  wire logic [1:0]      stop_decel_select       = ctrl_r[CTL_DECEL_LSB +: 2];
  wire logic            travel_direction_select = ctrl_r[CTL_DIR_BIT];
  wire logic            fully_closed            = ctrl_r[CTL_FULLY_BIT];
  wire logic            standard_mode           = ctrl_r[CTL_STD_BIT];
  wire logic            cont_torque_switch      = ctrl_r[CTL_CONT_BIT];
  wire logic [5:0]      own_master_num          = ctrl_r[CTL_OWN_LSB +: 6];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  logic                 aw_held_r;
  logic                 w_held_r;
  logic [ADDR_W-1:0]    aw_addr_r;
  logic [DATA_W-1:0]    w_data_r;
  logic [3:0]           w_strb_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;

  assign s_awready_o = !aw_held_r && !bvalid_r;
  assign s_wready_o  = !w_held_r && !bvalid_r;
  assign s_bvalid_o  = bvalid_r;
  assign s_bresp_o   = bresp_r;

  wire logic            aw_take  = s_awvalid_i && s_awready_o;
  wire logic            w_take   = s_wvalid_i && s_wready_o;
  wire logic            have_aw  = aw_held_r || aw_take;
  wire logic            have_w   = w_held_r || w_take;
  wire logic            wr_fire  = have_aw && have_w && !bvalid_r;
  wire logic [ADDR_W-1:0] wr_addr = aw_held_r ? aw_addr_r : s_awaddr_i;
  wire logic [DATA_W-1:0] wr_data = w_held_r ? w_data_r : s_wdata_i;
  wire logic [3:0]      wr_strb  = w_held_r ? w_strb_r : s_wstrb_i;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  wire logic            wr_ctrl  = wr_fire && (wr_addr == OFS_CTRL);
  wire logic            wr_sel1  = wr_fire && (wr_addr == OFS_TX_SEL1);
  wire logic            wr_sel2  = wr_fire && (wr_addr == OFS_TX_SEL2);
  wire logic            wr_mnum  = wr_fire && (wr_addr == OFS_MASTER_NUM);
  wire logic            wr_tcoef = wr_fire && (wr_addr == OFS_TRQ_COEF);
  wire logic            wr_scoef = wr_fire && (wr_addr == OFS_SPD_COEF);
  wire logic            wr_sadj  = wr_fire && (wr_addr == OFS_SPD_ADJ);
  wire logic            wr_iclr  = wr_fire && (wr_addr == OFS_IRQ_CLEAR);
  wire logic            wr_ien   = wr_fire && (wr_addr == OFS_IRQ_ENABLE);
  wire logic            wr_ok    = wr_ctrl || wr_sel1 || wr_sel2 || wr_mnum || wr_tcoef || wr_scoef
                                   || wr_sadj || wr_iclr || wr_ien;
  wire logic [31:0]     wr_merged_mnum  = merge({26'h0, master_num_r}, wr_data, wr_strb);
  wire logic [31:0]     wr_merged_tcoef = merge({23'h0, trq_coef_r}, wr_data, wr_strb);
  wire logic [31:0]     wr_merged_scoef = merge({23'h0, spd_coef_r}, wr_data, wr_strb);
  wire logic [31:0]     wr_merged_sadj  = merge({17'h0, spd_adj_r}, wr_data, wr_strb);
  wire logic [31:0]     wr_merged_ien   = merge({29'h0, irq_en_r}, wr_data, wr_strb);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take && !wr_fire)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_awaddr_i;
      end
      if (w_take && !wr_fire)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_wdata_i;
        w_strb_r <= s_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_bready_i)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Role bits and selectors reset to zero; stop deceleration select resets to 2
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_r       <= CTRL_RST;
      tx_sel1_r    <= ZERO_RST;
      tx_sel2_r    <= ZERO_RST;
      master_num_r <= 6'h00;
      trq_coef_r   <= 9'h000;
      spd_coef_r   <= 9'h000;
      spd_adj_r    <= 15'h0000;
      irq_en_r     <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_r <= merge(ctrl_r, wr_data, wr_strb) & 32'h0000_3FFF;
      end
      if (wr_sel1)
      begin
        tx_sel1_r <= merge(tx_sel1_r, wr_data, wr_strb);
      end
      if (wr_sel2)
      begin
        tx_sel2_r <= merge(tx_sel2_r, wr_data, wr_strb);
      end
      if (wr_mnum)
      begin
        master_num_r <= wr_merged_mnum[5:0];
      end
      if (wr_tcoef)
      begin
        trq_coef_r <= wr_merged_tcoef[8:0];
      end
      if (wr_scoef)
      begin
        spd_coef_r <= wr_merged_scoef[8:0];
      end
      if (wr_sadj)
      begin
        spd_adj_r <= wr_merged_sadj[14:0];
      end
      if (wr_ien)
      begin
        irq_en_r <= wr_merged_ien[EV_N-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration check
  wire logic            role_set     = master_role_select || slave_role_select;
  wire logic            is_master    = master_role_select && !slave_role_select;
  wire logic            is_slave     = slave_role_select && !master_role_select;
  wire logic            err_decel    = role_set && (stop_decel_select != 2'h0);
  wire logic            err_mode     = role_set && !standard_mode;
  wire logic            err_fully    = is_slave && fully_closed;
  wire logic            err_roles    = master_role_select && slave_role_select;
  wire logic            err_cont     = role_set && cont_torque_switch;
  // Out-of-range settings are treated as parameter errors rather than clamped
  wire logic            err_range    = is_slave && ((master_num_r > MASTER_NUM_MAX)
                                        || (trq_coef_r > COEF_MAX) || (spd_coef_r > COEF_MAX));
  wire logic            err_mnum     = is_master && (master_num_r != 6'h00);
  wire logic            param_err    = err_decel || err_mode || err_fully || err_roles || err_cont
                                       || err_range || err_mnum;
  // Follow only when nothing blocks master-slave operation
  wire logic            run_master   = is_master && !param_err;
  wire logic            run_slave    = is_slave && !param_err;

  ////////////////////////////////////////////////////////////////////////////
  // Slave datapath
  wire logic            rx_match     = rx_link_i.valid && (rx_link_i.master_num == master_num_r);
  logic signed [TRQ_W-1:0] rx_torque_r;
  logic [TRQ_W-1:0]     rx_speed_r;
  logic                 rx_servo_on_r;

  wire logic signed [25:0] trq_prod  = rx_torque_r * $signed({1'b0, trq_coef_r});
  wire logic signed [25:0] trq_scl   = trq_prod / $signed(COEF_SCALE);
  wire logic signed [TRQ_W-1:0] trq_sat = (trq_scl > 26'sd32767) ? 16'sh7FFF :
                                           (trq_scl < -26'sd32768) ? 16'sh8000 : trq_scl[TRQ_W-1:0];
  wire logic signed [TRQ_W-1:0] trq_pol = travel_direction_select ?
                                           ((trq_sat == 16'sh8000) ? 16'sh7FFF : -trq_sat) : trq_sat;
  wire logic [25:0]     spd_prod     = {10'h000, rx_speed_r} * {17'h0_0000, spd_coef_r};
  wire logic [25:0]     spd_scl      = spd_prod / COEF_SCALE;
  wire logic [TRQ_W-1:0] spd_sat     = (spd_scl > 26'h000FFFF) ? 16'hFFFF : spd_scl[TRQ_W-1:0];
  wire logic [TRQ_W-1:0] spd_floor   = (spd_sat < {1'b0, spd_adj_r}) ? {1'b0, spd_adj_r} : spd_sat;

  // Slave torque allowed only while both this axis and its master are servo-on; master torque needs only its own servo-on
  wire logic            slave_drive  = run_slave && servo_on_i && rx_servo_on_r && !overspeed_alarm_o;
  wire logic            master_drive = run_master && servo_on_i;

  wire logic [TRQ_W-1:0] speed_abs   = motor_speed_i[TRQ_W-1] ? (~motor_speed_i + 16'h0001) : motor_speed_i;
  wire logic            overspeed    = run_slave && servo_on_i && (speed_abs >= speed_limit_o);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_torque_r   <= 16'sh0000;
      rx_speed_r    <= 16'h0000;
      rx_servo_on_r <= 1'b0;
    end
    else if (rx_match)
    begin
      rx_torque_r   <= rx_link_i.torque;
      rx_speed_r    <= rx_link_i.speed_limit;
      rx_servo_on_r <= rx_link_i.servo_on;
    end
  end

  // Selected outputs: master passes its own loop, slave uses the received command
  wire logic signed [TRQ_W-1:0] torque_nxt = master_drive ? local_torque_i :
                                             slave_drive ? trq_pol : 16'sh0000;
  wire logic [TRQ_W-1:0] speed_nxt = is_slave ? spd_floor : local_speed_limit_i;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      torque_cmd_o            <= 16'sh0000;
      speed_limit_o           <= 16'h0000;
      motor_dir_cw_o          <= 1'b0;
      parameter_error_alarm_o <= 1'b0;
      overspeed_alarm_o       <= 1'b0;
    end
    else
    begin
      torque_cmd_o            <= torque_nxt;
      speed_limit_o           <= speed_nxt;
      motor_dir_cw_o          <= is_master && travel_direction_select;
      parameter_error_alarm_o <= param_err;
      // Overspeed holds until servo-off so the axis cannot restart on its own
      if (overspeed)
      begin
        overspeed_alarm_o <= 1'b1;
      end
      else if (!servo_on_i)
      begin
        overspeed_alarm_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master transmit: each word follows its selector
  wire logic [TRQ_W-1:0] tx_w1 = (tx_sel1_r == TXSEL_TORQUE) ? local_torque_i :
                                 (tx_sel1_r == TXSEL_SPEED) ? local_speed_limit_i : 16'h0000;
  wire logic [TRQ_W-1:0] tx_w2 = (tx_sel2_r == TXSEL_SPEED) ? local_speed_limit_i :
                                 (tx_sel2_r == TXSEL_TORQUE) ? local_torque_i : 16'h0000;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_link_o <= '0;
    end
    else
    begin
      tx_link_o.valid       <= run_master;
      tx_link_o.master_num  <= own_master_num;
      tx_link_o.servo_on    <= master_drive;
      tx_link_o.torque      <= run_master ? tx_w1 : 16'h0000;
      tx_link_o.speed_limit <= run_master ? tx_w2 : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over clear
  logic                 param_err_d_r;
  logic                 rx_on_d_r;
  wire logic [EV_N-1:0] ev_set = {run_slave && rx_on_d_r && !rx_servo_on_r,
                                  overspeed && !overspeed_alarm_o,
                                  param_err && !param_err_d_r};
  wire logic [EV_N-1:0] ev_clr = wr_iclr ? wr_data[EV_N-1:0] : 3'h0;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_stat_r    <= 3'h0;
      param_err_d_r <= 1'b0;
      rx_on_d_r     <= 1'b0;
    end
    else
    begin
      irq_stat_r    <= (irq_stat_r & ~ev_clr) | ev_set;
      param_err_d_r <= param_err;
      rx_on_d_r     <= rx_servo_on_r;
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, one cycle after the address is taken
  logic                 rvalid_r;
  logic [DATA_W-1:0]    rdata_r;
  logic [1:0]           rresp_r;

  assign s_arready_o = !rvalid_r;
  assign s_rvalid_o  = rvalid_r;
  assign s_rdata_o   = rdata_r;
  assign s_rresp_o   = rresp_r;

  wire logic [31:0]     status_word = {26'h0, rx_servo_on_r, slave_drive || master_drive,
                                       run_slave, run_master, overspeed_alarm_o, parameter_error_alarm_o};
  logic [31:0]          rd_word;
  logic                 rd_hit;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_araddr_i)
      OFS_CTRL:       rd_word = ctrl_r;
      OFS_TX_SEL1:    rd_word = tx_sel1_r;
      OFS_TX_SEL2:    rd_word = tx_sel2_r;
      OFS_MASTER_NUM: rd_word = {26'h0, master_num_r};
      OFS_TRQ_COEF:   rd_word = {23'h0, trq_coef_r};
      OFS_SPD_COEF:   rd_word = {23'h0, spd_coef_r};
      OFS_SPD_ADJ:    rd_word = {17'h0, spd_adj_r};
      OFS_STATUS:     rd_word = status_word;
      OFS_IRQ_STATUS: rd_word = {29'h0, irq_stat_r};
      OFS_IRQ_CLEAR:  rd_word = 32'h0000_0000;
      OFS_IRQ_ENABLE: rd_word = {29'h0, irq_en_r};
      OFS_TORQUE_OUT: rd_word = {{16{torque_cmd_o[TRQ_W-1]}}, torque_cmd_o};
      OFS_SPEED_OUT:  rd_word = {16'h0, speed_limit_o};
      default:        rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (s_arvalid_i && s_arready_o)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_rready_i)
    begin
      rvalid_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [core/mst_pkg.sv]
// Constants, register map and link carriers of the master-slave torque follow block
`default_nettype none
package mst_pkg;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned TRQ_W            = 16;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_TX_SEL1      = 8'h04;
  localparam logic [7:0]  OFS_TX_SEL2      = 8'h08;
  localparam logic [7:0]  OFS_MASTER_NUM   = 8'h0C;
  localparam logic [7:0]  OFS_TRQ_COEF     = 8'h10;
  localparam logic [7:0]  OFS_SPD_COEF     = 8'h14;
  localparam logic [7:0]  OFS_SPD_ADJ      = 8'h18;
  localparam logic [7:0]  OFS_STATUS       = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h20;
  localparam logic [7:0]  OFS_IRQ_CLEAR    = 8'h24;
  localparam logic [7:0]  OFS_IRQ_ENABLE   = 8'h28;
  localparam logic [7:0]  OFS_TORQUE_OUT   = 8'h2C;
  localparam logic [7:0]  OFS_SPEED_OUT    = 8'h30;
  // Control register fields
  localparam int unsigned CTL_MASTER_BIT   = 0;
  localparam int unsigned CTL_SLAVE_BIT    = 1;
  localparam int unsigned CTL_DECEL_LSB    = 2;
  localparam int unsigned CTL_DIR_BIT      = 4;
  localparam int unsigned CTL_FULLY_BIT    = 5;
  localparam int unsigned CTL_STD_BIT      = 6;
  localparam int unsigned CTL_CONT_BIT     = 7;
  localparam int unsigned CTL_OWN_LSB      = 8;
  localparam logic [31:0] CTRL_RST         = 32'h0000_0048;
  localparam logic [31:0] ZERO_RST         = 32'h0000_0000;
  // Transmit selector codes and setting limits
  localparam logic [31:0] TXSEL_TORQUE     = 32'h0000_0038;
  localparam logic [31:0] TXSEL_SPEED      = 32'h0000_003A;
  localparam logic [5:0]  MASTER_NUM_MAX   = 6'h20;
  localparam logic [8:0]  COEF_MAX         = 9'h1F4;
  localparam logic [25:0] COEF_SCALE       = 26'h0000064;
  // Interrupt event bits
  localparam int unsigned EV_PARAM_ERR     = 0;
  localparam int unsigned EV_OVERSPEED     = 1;
  localparam int unsigned EV_MASTER_OFF    = 2;
  localparam int unsigned EV_N             = 3;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic                    valid;
    logic [5:0]              master_num;
    logic                    servo_on;
    logic signed [TRQ_W-1:0] torque;
    logic [TRQ_W-1:0]        speed_limit;
  } mst_link_t;
endpackage
`default_nettype wire

// [testbench/mst_follow_sva.sv]
// Port-level assertions of the master-slave torque follow block
`default_nettype none
module mst_follow_sva
  import mst_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  input wire logic [1:0]              s_bresp_o,
  input wire logic                    s_bvalid_o,
  input wire logic                    s_bready_i,
  input wire logic                    s_arvalid_i,
  input wire logic                    s_arready_o,
  input wire logic                    s_rvalid_o,
  input wire logic                    servo_on_i,
  input wire mst_link_t               tx_link_o,
  input wire logic signed [TRQ_W-1:0] torque_cmd_o,
  input wire logic                    parameter_error_alarm_o,
  input wire logic                    overspeed_alarm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  bresp_hold_a: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write response dropped");
  read_answer_a: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
    else $error("read not answered");
  read_refuse_a: assert property (s_rvalid_o |-> !s_arready_o)
    else $error("read taken while busy");
  alarm_mute_a: assert property (parameter_error_alarm_o [*2] |-> torque_cmd_o == 16'sh0000 && !tx_link_o.valid)
    else $error("torque during alarm");
  servo_off_a: assert property (!servo_on_i |=> torque_cmd_o == 16'sh0000)
    else $error("torque without servo-on");
  ovs_hold_a: assert property (overspeed_alarm_o && servo_on_i |=> overspeed_alarm_o)
    else $error("overspeed dropped");
  ovs_clear_a: assert property (!servo_on_i |=> !overspeed_alarm_o)
    else $error("overspeed kept");
  ovs_mute_a: assert property (overspeed_alarm_o [*2] |-> torque_cmd_o == 16'sh0000)
    else $error("torque during overspeed");
  c_alarm: cover property ($rose(parameter_error_alarm_o));
  c_ovs: cover property ($rose(overspeed_alarm_o));
  c_tx: cover property (tx_link_o.valid);
endmodule
bind mst_follow mst_follow_sva i_sva (.clk_i, .reset_n_i, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_arvalid_i,
  .s_arready_o, .s_rvalid_o, .servo_on_i, .tx_link_o, .torque_cmd_o, .parameter_error_alarm_o, .overspeed_alarm_o);
`default_nettype wire

// [testbench/mst_ring_peer.sv]
// Model of the master axis sending its link word around the ring
`default_nettype none
module mst_ring_peer
  import mst_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      reset_n_i,
  input  wire logic      send_i,
  input  wire mst_link_t word_i,
  output var mst_link_t  link_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // Idle words flip every cycle so a stale payload never looks fresh
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      link_o <= '0;
    else if (send_i)
      link_o <= {1'b1, word_i[38:0]};
    else
      link_o <= {1'b0, ~link_o[38:0]};
  end
endmodule
`default_nettype wire

// [testbench/test_master_slave_torque_follow.sv]
// Self-checking bench of the master-slave torque follow block
`default_nettype none
module test_master_slave_torque_follow
  import mst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i, reset_n_i, s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o, s_bready_i;
  logic               s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i, servo_on_i, motor_dir_cw_o, irq_o, send;
  logic               parameter_error_alarm_o, overspeed_alarm_o;
  logic [7:0]         s_awaddr_i, s_araddr_i;
  logic [31:0]        s_wdata_i, s_rdata_o;
  logic [3:0]         s_wstrb_i;
  logic [1:0]         s_bresp_o, s_rresp_o;
  logic signed [15:0] local_torque_i, motor_speed_i, torque_cmd_o;
  logic [15:0]        local_speed_limit_i, speed_limit_o;
  mst_link_t          rx_link_i, tx_link_o, word;
  int                 n_errors, cmp_count;
  mst_follow i_dut (.clk_i, .reset_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i,
    .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o,
    .s_rresp_o, .s_rvalid_o, .s_rready_i, .servo_on_i, .local_torque_i, .local_speed_limit_i, .motor_speed_i,
    .rx_link_i, .tx_link_o, .torque_cmd_o, .speed_limit_o, .motor_dir_cw_o, .parameter_error_alarm_o,
    .overspeed_alarm_o, .irq_o);
  mst_ring_peer i_peer (.clk_i, .reset_n_i, .send_i(send), .word_i(word), .link_o(rx_link_i));
  ////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Sampled mid-cycle so registered outputs have settled
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    {s_awvalid_i, s_wvalid_i, s_bready_i} <= 3'h7;
    do
    begin
      @(posedge clk_i);
      if (s_awready_o)
        s_awvalid_i <= 1'b0;
      if (s_wready_o)
        s_wvalid_i <= 1'b0;
    end
    while (!s_bvalid_o);
    s_bready_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    s_araddr_i <= a;
    {s_arvalid_i, s_rready_i} <= 2'h3;
    do
    begin
      @(posedge clk_i);
      if (s_arready_o)
        s_arvalid_i <= 1'b0;
    end
    while (!s_rvalid_o);
    s_rready_i <= 1'b0;
    chk(e, s_rdata_o, "rdata");
    chk({30'h0, (a > OFS_SPEED_OUT) ? RESP_SLVERR : RESP_OKAY}, {30'h0, s_rresp_o}, "rresp");
  endtask
  task automatic sw(input logic [5:0] n, input logic on, input logic [15:0] tq, input logic [15:0] sp);
    @(posedge clk_i);
    send <= 1'b1;
    word <= '{1'b1, n, on, tq, sp};
    w(3);
  endtask
  task automatic t_reset();
    int a;
    rc(OFS_CTRL, CTRL_RST);
    for (a = 4; a <= 24; a += 4)
      rc(8'(a), ZERO_RST);
    rc(8'hFC, ZERO_RST);
  endtask
  task automatic t_master();
    @(posedge clk_i);
    servo_on_i <= 1'b1;
    local_torque_i <= 16'sh04D2;
    local_speed_limit_i <= 16'h0309;
    wr(OFS_TX_SEL1, TXSEL_TORQUE);
    wr(OFS_TX_SEL2, TXSEL_SPEED);
    wr(OFS_CTRL, 32'h0000_0051);
    w(1);
    chk(32'h0000_0001, {31'h0, tx_link_o.valid}, "tx valid");
    chk(32'h0000_04D2, {16'h0, tx_link_o.torque}, "tx torque");
    chk(32'h0000_0309, {16'h0, tx_link_o.speed_limit}, "tx speed");
    chk(32'h0000_0001, {31'h0, motor_dir_cw_o}, "dir");
  endtask
  task automatic t_alarm();
    logic [31:0] bad [5] = '{32'h0000_0049, 32'h0000_0001, 32'h0000_0062, 32'h0000_00C1, 32'h0000_0043};
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    foreach (bad[i])
    begin
      wr(OFS_CTRL, bad[i]);
      w(1);
      chk(32'h0000_0001, {31'h0, parameter_error_alarm_o}, "alarm");
      wr(OFS_CTRL, 32'h0000_0041);
    end
    chk(32'h0000_0001, {31'h0, irq_o}, "irq");
    wr(OFS_IRQ_ENABLE, ZERO_RST);
    chk(32'h0000_0000, {31'h0, irq_o}, "irq masked");
    wr(OFS_IRQ_CLEAR, 32'h0000_0007);
    rc(OFS_IRQ_STATUS, ZERO_RST);
    wr(OFS_CTRL, 32'h0000_0061);
    w(1);
    chk(32'h0000_0000, {31'h0, parameter_error_alarm_o}, "alarm");
  endtask
  task automatic t_slave();
    @(posedge clk_i);
    servo_on_i <= 1'b0;
    wr(OFS_SPD_ADJ, 32'h0000_0064);
    wr(OFS_MASTER_NUM, 32'h0000_0005);
    wr(OFS_TRQ_COEF, 32'h0000_00C8);
    wr(OFS_SPD_COEF, 32'h0000_0032);
    wr(OFS_CTRL, 32'h0000_0052);
    sw(6'h05, 1'b1, 16'h03E8, 16'h0FA0);
    @(posedge clk_i);
    servo_on_i <= 1'b1;
    w(2);
    chk(32'hFFFF_F830, 32'(torque_cmd_o), "torque");
    chk(32'h0000_07D0, {16'h0, speed_limit_o}, "speed");
    chk(32'h0000_0000, {31'h0, motor_dir_cw_o}, "dir");
    sw(6'h05, 1'b1, 16'h03E8, 16'h0064);
    chk(32'h0000_0064, {16'h0, speed_limit_o}, "speed floor");
    sw(6'h06, 1'b1, 16'h012C, 16'h0FA0);
    chk(32'hFFFF_F830, 32'(torque_cmd_o), "other master");
    sw(6'h05, 1'b0, 16'h03E8, 16'h0064);
    chk(32'h0000_0000, 32'(torque_cmd_o), "master off");
    sw(6'h05, 1'b1, 16'h03E8, 16'h0064);
    @(posedge clk_i);
    motor_speed_i <= 16'shFF6A;
    w(2);
    chk(32'h0000_0001, {31'h0, overspeed_alarm_o}, "overspeed");
    w(1);
    chk(32'h0, 32'(torque_cmd_o), "ovs torque");
  endtask
  initial
  begin
    {reset_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i, servo_on_i, send} = '0;
    {s_awaddr_i, s_araddr_i, s_wdata_i, local_torque_i, motor_speed_i, local_speed_limit_i} = '0;
    s_wstrb_i = 4'hF;
    word = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_master();
    t_alarm();
    t_slave();
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
